// ==== dam_pkg.sv ====
// package: constants and carriers for the address generator and memory map decode block
package dam_pkg;
  // widths of the address path
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 8;
  localparam int PTR_W = 16;
  localparam int EXT_W = 20;
  localparam int IO_W = 18;
  localparam int NUM_PTR = 4;
  localparam int PTR_SEL_W = $clog2(NUM_PTR);
  localparam int NUM_SETS = 2;
  localparam int NUM_GEN = 2;
  localparam int NUM_BANK = 4;
  localparam int BANK_SEL_W = $clog2(NUM_BANK);
  localparam int RAM_BLKS = 3;
  localparam int RAM_SEL_W = 2;
  // decode sources: two generators and the sequencer
  localparam int NUM_SRC = 3;
  localparam int SRC_D0 = 0;
  localparam int SRC_D1 = 1;
  localparam int SRC_PC = 2;
  // map landmarks
  localparam logic [PAGE_W-1:0] PAGE_INT = 8'h00;
  localparam logic [ADDR_W-1:0] BOOT_BASE = 24'hFF0000;
  localparam logic [ADDR_W-1:0] BOOT_LAST = 24'hFF0FFF;
  localparam logic [PAGE_W-1:0] IO_INT_PAGES = 8'h20;
  // reset start pages of banks 3..0, one byte each
  localparam logic [NUM_BANK*PAGE_W-1:0] BANK_RST = 32'hC0804001;
  // register word indices (byte address is four times the index)
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_DPAGE0 = 4'h1;
  localparam logic [REG_AW-1:0] REG_DPAGE1 = 4'h2;
  localparam logic [REG_AW-1:0] REG_JPAGE = 4'h3;
  localparam logic [REG_AW-1:0] REG_BANK0 = 4'h4;
  localparam logic [REG_AW-1:0] REG_BANK_LAST = 4'h7;
  localparam logic [REG_AW-1:0] REG_PC = 4'h8;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h9;
  // control register fields
  localparam int CTRL_W = 3;
  localparam int CTRL_SEC = 0;
  localparam int CTRL_EXT8 = 1;
  localparam int CTRL_PACK24 = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam int BUS_DW = 32;
  localparam int BUS_BE = 4;

  typedef enum logic [2:0] {DAM_SEQ_NEXT = 3'b000, DAM_SEQ_HOLD = 3'b001, DAM_SEQ_REL = 3'b010,
    DAM_SEQ_DIRECT = 3'b011, DAM_SEQ_INDIR = 3'b100} dam_seq_op_t;
  typedef enum logic [1:0] {DAM_LD_IDX = 2'b00, DAM_LD_MOD = 2'b01, DAM_LD_LEN = 2'b10,
    DAM_LD_BASE = 2'b11} dam_ld_kind_t;
  typedef enum logic [1:0] {DAM_OWN_IO = 2'b00, DAM_OWN_D0 = 2'b01, DAM_OWN_D1 = 2'b10,
    DAM_OWN_PC = 2'b11} dam_own_t;
  typedef enum logic {DAM_BUS_IDLE = 1'b0, DAM_BUS_ACK = 1'b1} dam_bus_st_t;
  typedef struct packed {logic valid; logic [PTR_SEL_W-1:0] ptr; logic [PTR_SEL_W-1:0] mod;
    logic post;} dam_acc_t;
  typedef struct packed {logic valid; logic gen; dam_ld_kind_t kind; logic [PTR_SEL_W-1:0] sel;
    logic [PTR_W-1:0] data;} dam_ld_t;
  typedef struct packed {dam_seq_op_t op; logic [ADDR_W-1:0] imm;} dam_seq_t;
  typedef struct packed {logic valid; logic [IO_W-1:0] addr;} dam_io_t;
  typedef struct packed {logic [RAM_BLKS-1:0] ram; logic rom; logic ext;} dam_sel_t;
endpackage

// ==== dam_addr_map.sv ====
// design: data address generators, sequencer address and memory map decode
// Notes on behaviour
// - two generators, four 16-bit pointers, updated on use
// - pointer pre/post modified by one modify register
// - nonzero length wraps pointer around base
// - circular buffer stays inside one 64K page
// - secondary register set, switched for context swap
// - 8-bit page register tops 24-bit data address
// - second page register pages external data
// - 24-bit program counter, relative flow from it
// - direct transfer takes immediate 24-bit target
// - indirect transfer upper byte from jump page
// - map is 256 pages of 64K words
// - page 0 holds three 16K RAM blocks
// - 4K boot ROM at FF0000, reset starts there
// - four external banks, each own low select
// - I/O pages 1K; low 32 on chip
// - external address 20 lines, width and packing
// - all spaces share one external bus
// - program and data fetch decoded same cycle
// - bank start pages writable at runtime
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module dam_addr_map
  import dam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [REG_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BUS_BE-1:0] avs_byteenable,
  input wire logic [BUS_DW-1:0] avs_writedata,
  output logic [BUS_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // core side requests
  input wire dam_acc_t [NUM_GEN-1:0] dag_acc,
  input wire dam_ld_t reg_ld,
  input wire dam_seq_t seq_cmd,
  input wire dam_io_t io_req,
  // generated addresses and decode
  output logic [NUM_GEN-1:0][ADDR_W-1:0] dag_addr,
  output logic [ADDR_W-1:0] prog_addr_bus,
  output dam_sel_t [NUM_SRC-1:0] src_sel,
  // shared external bus
  output logic [EXT_W-1:0] ext_addr,
  output dam_own_t ext_owner,
  output logic ext_valid,
  output logic ext_stall,
  output logic [NUM_BANK-1:0] bank_select_n,
  output logic io_space_select_n,
  output logic periph_sel,
  output logic [IO_W-1:0] periph_addr
);

  // configuration state
  dam_bus_st_t bus_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [PAGE_W-1:0] dpage_q [NUM_GEN];
  logic [PAGE_W-1:0] jpage_q;
  logic [PAGE_W-1:0] bank_q [NUM_BANK];
  logic [ADDR_W-1:0] program_counter_q;
  logic [ADDR_W-1:0] program_counter_d;

  // active register set, one bit for all generators
  wire set_sel = ctrl_q[CTRL_SEC];

  // bus decode
  wire bus_req = avs_read | avs_write;
  wire bus_start = bus_req && (bus_q == DAM_BUS_IDLE);
  wire bus_done = bus_req && (bus_q == DAM_BUS_ACK);
  // writable registers are one byte wide at most, so only lane 0 matters
  wire wr_en = bus_done && avs_write && avs_byteenable[0];
  wire [PAGE_W-1:0] wr_byte = avs_writedata[PAGE_W-1:0];
  wire is_bank = (avs_address >= REG_BANK0) && (avs_address <= REG_BANK_LAST);
  wire [BANK_SEL_W-1:0] bank_idx = avs_address[BANK_SEL_W-1:0];
  wire [BUS_DW-1:0] status = BUS_DW'({ext_stall, ext_valid, io_space_select_n, periph_sel,
    ext_owner});
  // unmapped indices read as zero
  wire [BUS_DW-1:0] rd_data =
    (avs_address == REG_CTRL) ? BUS_DW'(ctrl_q) :
    (avs_address == REG_DPAGE0) ? BUS_DW'(dpage_q[0]) :
    (avs_address == REG_DPAGE1) ? BUS_DW'(dpage_q[1]) :
    (avs_address == REG_JPAGE) ? BUS_DW'(jpage_q) :
    is_bank ? BUS_DW'(bank_q[bank_idx]) :
    (avs_address == REG_PC) ? BUS_DW'(program_counter_q) :
    (avs_address == REG_STATUS) ? status : '0;

  // register slave: one wait cycle, then the request completes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bus_q <= DAM_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else
    begin
      bus_q <= bus_start ? DAM_BUS_ACK : DAM_BUS_IDLE;
      avs_waitrequest <= !bus_start;
      // read data captured a cycle early so it comes from a flop
      if (bus_start)
        avs_readdata <= rd_data;
    end
  end

  // software writable configuration
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RST;
      jpage_q <= '0;
      for (int g = 0; g < NUM_GEN; g++)
        dpage_q[g] <= '0;
      for (int k = 0; k < NUM_BANK; k++)
        bank_q[k] <= BANK_RST[k*PAGE_W +: PAGE_W];
    end
    else if (wr_en)
    begin
      unique case (avs_address)
        REG_CTRL: ctrl_q <= avs_writedata[CTRL_W-1:0];
        REG_DPAGE0: dpage_q[0] <= wr_byte;
        REG_DPAGE1: dpage_q[1] <= wr_byte;
        REG_JPAGE: jpage_q <= wr_byte;
        default:
        begin
          // bank start pages move at runtime; other indices ignored
          if (is_bank)
            bank_q[bank_idx] <= wr_byte;
        end
      endcase
    end
  end

  // address generators
  logic [ADDR_W-1:0] dag_a [NUM_GEN];
  logic [PTR_W-1:0] jump_src [NUM_GEN];

  for (genvar g = 0; g < NUM_GEN; g++)
  begin : gen_dag
    // index, modify, length, base per set
    logic [PTR_W-1:0] i_q [NUM_SETS][NUM_PTR];
    logic [PTR_W-1:0] m_q [NUM_SETS][NUM_PTR];
    logic [PTR_W-1:0] l_q [NUM_SETS][NUM_PTR];
    logic [PTR_W-1:0] b_q [NUM_SETS][NUM_PTR];
    wire dam_acc_t acc = dag_acc[g];
    wire [PTR_W-1:0] cur_i = i_q[set_sel][acc.ptr];
    wire [PTR_W-1:0] cur_m = m_q[set_sel][acc.mod];
    wire [PTR_W-1:0] cur_l = l_q[set_sel][acc.ptr];
    wire [PTR_W-1:0] cur_b = b_q[set_sel][acc.ptr];
    // two spare bits: one for carry, one for sign of modify
    wire [PTR_W+1:0] sum = {2'b00, cur_i} + {{2{cur_m[PTR_W-1]}}, cur_m};
    wire [PTR_W+1:0] top = {2'b00, cur_b} + {2'b00, cur_l};
    wire below = sum[PTR_W+1] || (sum < {2'b00, cur_b});
    wire above = !sum[PTR_W+1] && (sum >= top);
    wire circ = (cur_l != '0);
    // one correction only: modify must not exceed length
    wire [PTR_W+1:0] wrapped = above ? (sum - {2'b00, cur_l}) :
      below ? (sum + {2'b00, cur_l}) : sum;
    // only the low half wraps, page never changes
    wire [PTR_W-1:0] nxt = circ ? wrapped[PTR_W-1:0] : sum[PTR_W-1:0];
    wire [PTR_W-1:0] use_ptr = acc.post ? cur_i : nxt;
    wire ld_hit = reg_ld.valid && (reg_ld.gen == 1'(g));
    // page register above pointer, circular buffer locked in its page
    assign dag_a[g] = {dpage_q[g], use_ptr};
    assign jump_src[g] = i_q[set_sel][seq_cmd.imm[PTR_SEL_W-1:0]];

    // pointer update on use; a core load in the same cycle wins
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        for (int s = 0; s < NUM_SETS; s++)
        begin
          for (int p = 0; p < NUM_PTR; p++)
          begin
            i_q[s][p] <= '0;
            m_q[s][p] <= '0;
            l_q[s][p] <= '0;
            b_q[s][p] <= '0;
          end
        end
      end
      else
      begin
        if (acc.valid)
          i_q[set_sel][acc.ptr] <= nxt;
        if (ld_hit)
        begin
          unique case (reg_ld.kind)
            DAM_LD_IDX: i_q[set_sel][reg_ld.sel] <= reg_ld.data;
            DAM_LD_MOD: m_q[set_sel][reg_ld.sel] <= reg_ld.data;
            DAM_LD_LEN: l_q[set_sel][reg_ld.sel] <= reg_ld.data;
            DAM_LD_BASE: b_q[set_sel][reg_ld.sel] <= reg_ld.data;
          endcase
        end
      end
    end
  end

  // sequencer next address
  wire [ADDR_W-1:0] pc_inc = program_counter_q + ADDR_W'(1);
  wire [ADDR_W-1:0] pc_rel = program_counter_q + seq_cmd.imm;
  wire [ADDR_W-1:0] pc_ind = {jpage_q, jump_src[0]};

  // next program counter from the sequencer command
  always_comb
  begin
    unique case (seq_cmd.op)
      DAM_SEQ_NEXT: program_counter_d = pc_inc;
      DAM_SEQ_HOLD: program_counter_d = program_counter_q;
      DAM_SEQ_REL: program_counter_d = pc_rel;
      DAM_SEQ_DIRECT: program_counter_d = seq_cmd.imm;
      DAM_SEQ_INDIR: program_counter_d = pc_ind;
      default: program_counter_d = program_counter_q;
    endcase
  end

  // program counter starts in boot rom
  always_ff @(posedge mclk)
  begin
    if (reset)
      program_counter_q <= BOOT_BASE;
    else
      program_counter_q <= program_counter_d;
  end
  assign prog_addr_bus = program_counter_q;

  // decode sources: both data generators and the fetch, in parallel
  logic [ADDR_W-1:0] src_a [NUM_SRC];
  logic src_v [NUM_SRC];
  dam_sel_t sel_d [NUM_SRC];
  wire [NUM_BANK-1:0] bank_hit [NUM_SRC];
  wire [NUM_SRC-1:0] ext_req;
  assign src_a[SRC_D0] = dag_a[0];
  assign src_a[SRC_D1] = dag_a[1];
  assign src_a[SRC_PC] = program_counter_d;
  assign src_v[SRC_D0] = dag_acc[0].valid;
  assign src_v[SRC_D1] = dag_acc[1].valid;
  assign src_v[SRC_PC] = (seq_cmd.op != DAM_SEQ_HOLD);

  for (genvar s = 0; s < NUM_SRC; s++)
  begin : gen_dec
    // page number is the top byte of the word address
    wire [PAGE_W-1:0] pg = src_a[s][ADDR_W-1 -: PAGE_W];
    wire [PTR_W-1:0] off = src_a[s][PTR_W-1:0];
    wire rom = (src_a[s] >= BOOT_BASE) && (src_a[s] <= BOOT_LAST);
    wire [RAM_BLKS-1:0] ram_hit;
    for (genvar k = 0; k < RAM_BLKS; k++)
    begin : gen_ram
      // 16K blocks picked by the top two offset bits of page 0
      assign ram_hit[k] = src_v[s] && (pg == PAGE_INT) &&
        (off[PTR_W-1 -: RAM_SEL_W] == RAM_SEL_W'(k));
    end
    // the rest of page 0 above the blocks decodes to nothing
    wire ext = src_v[s] && (pg != PAGE_INT) && !rom;
    assign sel_d[s] = {ram_hit, src_v[s] && rom, ext};
    assign ext_req[s] = ext;
    for (genvar k = 0; k < NUM_BANK; k++)
    begin : gen_bank
      // a bank runs from its start page up to the next bank's start
      if (k == NUM_BANK - 1)
      begin : gen_last
        assign bank_hit[s][k] = (pg >= bank_q[k]);
      end
      else
      begin : gen_mid
        assign bank_hit[s][k] = (pg >= bank_q[k]) && (pg < bank_q[k+1]);
      end
    end
  end

  // i/o space: 1K pages, low pages stay on chip
  wire [PAGE_W-1:0] io_page = io_req.addr[IO_W-1 -: PAGE_W];
  wire io_ext = io_req.valid && (io_page >= IO_INT_PAGES);
  wire io_int = io_req.valid && (io_page < IO_INT_PAGES);

  // shared external bus: i/o, data 0, data 1, then fetch
  wire d0_win = !io_ext && ext_req[SRC_D0];
  wire d1_win = !io_ext && !ext_req[SRC_D0] && ext_req[SRC_D1];
  wire pc_win = !io_ext && !ext_req[SRC_D0] && !ext_req[SRC_D1] && ext_req[SRC_PC];
  wire any_ext = io_ext || (|ext_req);
  // losers are flagged, the core is expected to retry them
  wire clash = (io_ext && (|ext_req)) || (ext_req[SRC_D0] && (|ext_req[SRC_PC:SRC_D1])) ||
    (ext_req[SRC_D1] && ext_req[SRC_PC]);
  wire dam_own_t own_d = io_ext ? DAM_OWN_IO : d0_win ? DAM_OWN_D0 :
    d1_win ? DAM_OWN_D1 : DAM_OWN_PC;
  // external data always paged by the second page register
  wire [ADDR_W-1:0] win_word = io_ext ? ADDR_W'(io_req.addr) :
    d0_win ? {dpage_q[1], src_a[SRC_D0][PTR_W-1:0]} :
    d1_win ? {dpage_q[1], src_a[SRC_D1][PTR_W-1:0]} : src_a[SRC_PC];
  wire [NUM_BANK-1:0] win_bank = d0_win ? bank_hit[SRC_D0] :
    d1_win ? bank_hit[SRC_D1] : pc_win ? bank_hit[SRC_PC] : '0;

  // external word to pin address: 8-bit bus and packed wide words
  wire ext8 = ctrl_q[CTRL_EXT8];
  wire wide = pc_win && ctrl_q[CTRL_PACK24];
  wire [ADDR_W+1:0] w = {2'b00, win_word};
  wire [ADDR_W+1:0] w2 = {w[ADDR_W:0], 1'b0};
  // three bytes per packed word on 8-bit, two otherwise
  wire [ADDR_W+1:0] phys = ext8 ? (wide ? (w + w2) : w2) : (wide ? w2 : w);

  // registered outputs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int g = 0; g < NUM_GEN; g++)
        dag_addr[g] <= '0;
      src_sel <= '0;
      ext_addr <= '0;
      ext_owner <= DAM_OWN_IO;
      ext_valid <= 1'b0;
      ext_stall <= 1'b0;
      bank_select_n <= '1;
      io_space_select_n <= 1'b1;
      periph_sel <= 1'b0;
      periph_addr <= '0;
    end
    else
    begin
      for (int g = 0; g < NUM_GEN; g++)
        dag_addr[g] <= dag_a[g];
      for (int s = 0; s < NUM_SRC; s++)
        src_sel[s] <= sel_d[s];
      ext_addr <= phys[EXT_W-1:0];
      ext_owner <= own_d;
      ext_valid <= any_ext;
      ext_stall <= clash;
      bank_select_n <= ~win_bank;
      io_space_select_n <= !io_ext;
      periph_sel <= io_int;
      periph_addr <= io_req.addr;
    end
  end

endmodule // dam_addr_map

// ==== dam_addr_map_asserts.sv ====
// checker: port level assertions for the address map block
`timescale 1ns/1ps
module dam_addr_map_asserts
  import dam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic avs_waitrequest,
  input wire dam_seq_t seq_cmd,
  input wire dam_io_t io_req,
  input wire logic [ADDR_W-1:0] prog_addr_bus,
  input wire dam_sel_t [NUM_SRC-1:0] src_sel,
  input wire logic ext_valid,
  input wire logic ext_stall,
  input wire logic [NUM_BANK-1:0] bank_select_n,
  input wire logic io_space_select_n,
  input wire logic periph_sel,
  input wire logic [IO_W-1:0] periph_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // io page number below 32 stays on chip
  wire logic io_low = (io_req.addr[IO_W-1:10] < IO_INT_PAGES);
  // direct transfer command on the sequencer this cycle
  wire logic seq_dir = (seq_cmd.op == DAM_SEQ_DIRECT);

  a_boot_start: assert property ($fell(reset) |-> prog_addr_bus == BOOT_BASE)
    else $error("fetch address not at boot rom after reset");
  a_direct_target: assert property (seq_dir |=> prog_addr_bus == $past(seq_cmd.imm))
    else $error("direct transfer missed its target");
  a_rel_target: assert property (seq_cmd.op == DAM_SEQ_REL |=>
    prog_addr_bus == $past(prog_addr_bus) + $past(seq_cmd.imm))
    else $error("relative transfer not based on counter");
  a_hold_pc: assert property (seq_cmd.op == DAM_SEQ_HOLD |=> $stable(prog_addr_bus))
    else $error("counter moved while held");
  a_boot_decode: assert property (seq_dir && seq_cmd.imm[23:12] == 12'hFF0 |=>
    src_sel[SRC_PC].rom && !src_sel[SRC_PC].ext)
    else $error("boot rom fetch not decoded");
  a_ram_decode: assert property (seq_dir && seq_cmd.imm[23:16] == PAGE_INT &&
    seq_cmd.imm[15:14] != 2'h3 |=> src_sel[SRC_PC].ram == 3'h1 << $past(seq_cmd.imm[15:14]))
    else $error("page zero ram block decode wrong");
  a_bank_single: assert property (!(&bank_select_n) |-> ext_valid && $onehot(~bank_select_n))
    else $error("bank select without a single external access");
  a_io_onchip: assert property (io_req.valid && io_low |=> periph_sel &&
    io_space_select_n && periph_addr == $past(io_req.addr))
    else $error("on chip io page not decoded");
  a_io_external: assert property (io_req.valid && !io_low |=>
    !io_space_select_n && !periph_sel)
    else $error("external io page select missing");
  a_stall_owner: assert property (ext_stall |-> ext_valid)
    else $error("shared bus stall without any owner");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule // dam_addr_map_asserts

bind dam_addr_map dam_addr_map_asserts i_dam_addr_map_asserts (.mclk(mclk), .reset(reset),
  .avs_waitrequest(avs_waitrequest), .seq_cmd(seq_cmd), .io_req(io_req),
  .prog_addr_bus(prog_addr_bus), .src_sel(src_sel), .ext_valid(ext_valid),
  .ext_stall(ext_stall), .bank_select_n(bank_select_n), .io_space_select_n(io_space_select_n),
  .periph_sel(periph_sel), .periph_addr(periph_addr));

// ==== dam_ext_mem.sv ====
// partner model: external memory banks on the shared bus
`timescale 1ns/1ps
module dam_ext_mem
  import dam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ext_valid,
  input wire logic [NUM_BANK-1:0] bank_select_n,
  input wire logic [EXT_W-1:0] ext_addr,
  output logic [7:0] hits,
  output logic [EXT_W-1:0] last_addr
);
  // a bank chip only answers its own low select; count those cycles
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hits <= 8'h00;
      last_addr <= '0;
    end
    else if (ext_valid && !(&bank_select_n))
    begin
      hits <= hits + 8'h01;
      last_addr <= ext_addr;
    end
  end
endmodule // dam_ext_mem

// ==== dam_addr_map_bench.sv ====
// testbench: random and corner stimulus for the address map block
`timescale 1ns/1ps
module dam_addr_map_bench
  import dam_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [REG_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BUS_BE-1:0] avs_byteenable = 4'hF;
  logic [BUS_DW-1:0] avs_writedata = '0;
  logic [BUS_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  dam_acc_t [NUM_GEN-1:0] dag_acc = '0;
  dam_ld_t reg_ld = '0;
  dam_seq_t seq_cmd = '{DAM_SEQ_HOLD, 24'h000000};
  dam_io_t io_req = '0;
  logic [NUM_GEN-1:0][ADDR_W-1:0] dag_addr;
  logic [ADDR_W-1:0] prog_addr_bus;
  dam_sel_t [NUM_SRC-1:0] src_sel;
  logic [EXT_W-1:0] ext_addr;
  dam_own_t ext_owner;
  logic ext_valid;
  logic ext_stall;
  logic [NUM_BANK-1:0] bank_select_n;
  logic io_space_select_n;
  logic periph_sel;
  logic [IO_W-1:0] periph_addr;
  logic [7:0] hits;
  logic [EXT_W-1:0] last_addr;
  int fails = 0;
  int checked = 0;
  logic [31:0] rnd = 32'h000167C7; // fixed seed of the shift register
  logic [7:0] bstart [NUM_BANK] = '{8'h01, 8'h40, 8'h80, 8'hC0}; // bench copy of bank starts
  logic [7:0] pgs [6] = '{8'h01, 8'h4F, 8'h50, 8'h80, 8'hC0, 8'hFE}; // bank edge pages
  logic [31:0] q; // last read data
  logic [15:0] i0;
  logic [15:0] m0;
  logic [7:0] h0; // partner hit count before a run

  // core clock, 20 ns period
  initial
  begin
    forever #10 mclk = ~mclk;
  end

  dam_addr_map i_dam_addr_map (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dag_acc(dag_acc), .reg_ld(reg_ld), .seq_cmd(seq_cmd),
    .io_req(io_req), .dag_addr(dag_addr), .prog_addr_bus(prog_addr_bus), .src_sel(src_sel),
    .ext_addr(ext_addr), .ext_owner(ext_owner), .ext_valid(ext_valid), .ext_stall(ext_stall),
    .bank_select_n(bank_select_n), .io_space_select_n(io_space_select_n),
    .periph_sel(periph_sel), .periph_addr(periph_addr));
  dam_ext_mem i_dam_ext_mem (.mclk(mclk), .reset(reset), .ext_valid(ext_valid),
    .bank_select_n(bank_select_n), .ext_addr(ext_addr), .hits(hits), .last_addr(last_addr));

  // next pseudo random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pointer after modify, one circular correction when a length is set
  function automatic logic [15:0] modw(input logic [15:0] i, m, b, l);
    logic [15:0] n;
    n = i + m;
    if (l != 16'h0000 && n >= b + l)
      n = n - l;
    else if (l != 16'h0000 && n < b)
      n = n + l;
    return n;
  endfunction
  // expected low select: highest bank whose start is not above the page
  function automatic logic [3:0] bsel(input logic [7:0] pg);
    logic [3:0] s;
    s = 4'hF;
    for (int k = 0; k < NUM_BANK; k++)
      if (pg >= bstart[k])
        s = ~(4'h1 << k);
    return s;
  endfunction
  // one counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 16; n++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 16)
    begin
      fails++;
      summarize();
    end
  endtask
  // pass the sampling edge, drop the pulses, settle at mid cycle
  task automatic issue();
    @(posedge mclk);
    dag_acc <= '0;
    reg_ld <= '0;
    seq_cmd <= '{DAM_SEQ_HOLD, 24'h000000};
    io_req <= '0;
    @(negedge mclk);
  endtask
  task automatic ld(input logic g, input dam_ld_kind_t k, input logic [1:0] s,
    input logic [15:0] d);
    @(posedge mclk);
    reg_ld <= '{1'b1, g, k, s, d};
    issue();
  endtask
  task automatic acc(input logic g, input logic [1:0] p, input logic [1:0] m, input logic post);
    @(posedge mclk);
    dag_acc[g] <= '{1'b1, p, m, post};
    issue();
  endtask
  task automatic seq(input dam_seq_op_t op, input logic [23:0] imm);
    @(posedge mclk);
    seq_cmd <= '{op, imm};
    issue();
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(prog_addr_bus, BOOT_BASE);
    chk(bank_select_n, 4'hF);
    for (int k = 0; k < NUM_BANK; k++)
    begin
      bus(1'b0, REG_BANK0 + 4'(k), '0);
      chk(q, bstart[k]);
    end
    // move bank 1 at runtime; a write without lane 0 must not land
    bstart[1] = 8'h50;
    bus(1'b1, REG_BANK0 + 4'h1, 32'h00000050);
    avs_byteenable <= 4'hE;
    bus(1'b1, REG_BANK0 + 4'h2, 32'h00000011);
    avs_byteenable <= 4'hF;
    bus(1'b0, REG_BANK0 + 4'h1, '0);
    chk(q, 32'h00000050);
    bus(1'b0, REG_BANK0 + 4'h2, '0);
    chk(q, 32'h00000080);
    bus(1'b0, 4'hA, '0);
    chk(q, 32'h00000000);
    bus(1'b1, REG_DPAGE0, 32'h00000012);
    bus(1'b1, REG_DPAGE1, 32'h00000034);
    // random pointers: post modify shows old pointer, pre shows twice modified
    repeat (6)
    begin
      rnd = lfsr(rnd);
      i0 = rnd[31:16];
      m0 = rnd[15:0];
      ld(rnd[0], DAM_LD_IDX, rnd[2:1], i0);
      ld(rnd[0], DAM_LD_MOD, rnd[2:1], m0);
      ld(rnd[0], DAM_LD_LEN, rnd[2:1], 16'h0000);
      acc(rnd[0], rnd[2:1], rnd[2:1], 1'b1);
      chk(dag_addr[rnd[0]], {rnd[0] ? 8'h34 : 8'h12, i0});
      acc(rnd[0], rnd[2:1], rnd[2:1], 1'b0);
      chk(dag_addr[rnd[0]], {rnd[0] ? 8'h34 : 8'h12, i0 + m0 + m0});
    end
    // 16 word ring at 0x0100: wrap past the top, then below the base
    ld(1'b0, DAM_LD_BASE, 2'h3, 16'h0100);
    ld(1'b0, DAM_LD_LEN, 2'h3, 16'h0010);
    ld(1'b0, DAM_LD_IDX, 2'h3, 16'h010C);
    i0 = 16'h010C;
    for (int j = 0; j < 2; j++)
    begin
      m0 = j ? 16'hFFF8 : 16'h0008;
      ld(1'b0, DAM_LD_MOD, 2'h3, m0);
      acc(1'b0, 2'h3, 2'h3, 1'b0);
      i0 = modw(i0, m0, 16'h0100, 16'h0010);
      chk(dag_addr[0], {8'h12, i0});
    end
    // each register set keeps its own pointer
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, REG_CTRL, 32'(j));
      ld(1'b1, DAM_LD_MOD, 2'h0, 16'h0000);
      ld(1'b1, DAM_LD_IDX, 2'h0, j ? 16'h2222 : 16'h1111);
    end
    for (int j = 1; j >= 0; j--)
    begin
      bus(1'b1, REG_CTRL, 32'(j));
      acc(1'b1, 2'h0, 2'h0, 1'b1);
      chk(dag_addr[1], {8'h34, j ? 16'h2222 : 16'h1111});
    end
    // direct, negative relative, indirect and linear program flow
    seq(DAM_SEQ_DIRECT, 24'h001234);
    chk(prog_addr_bus, 24'h001234);
    seq(DAM_SEQ_REL, 24'hFFFFF0);
    chk(prog_addr_bus, 24'h001224);
    bus(1'b1, REG_JPAGE, 32'h00000005);
    ld(1'b0, DAM_LD_IDX, 2'h1, 16'hABCD);
    seq(DAM_SEQ_INDIR, 24'h000001);
    chk(prog_addr_bus, 24'h05ABCD);
    seq(DAM_SEQ_NEXT, '0);
    bus(1'b0, REG_PC, '0);
    chk(q, 32'h0005ABCE);
    // fetches at every bank start page, and on both sides of the bank 1 start
    h0 = hits;
    for (int j = 0; j < 6; j++)
    begin
      seq(DAM_SEQ_DIRECT, {pgs[j], 16'h0000});
      chk(bank_select_n, bsel(pgs[j]));
      chk(ext_owner, DAM_OWN_PC);
    end
    @(negedge mclk);
    chk(hits - h0, 8'h06);
    chk(last_addr, 20'hE0000);
    for (int j = 0; j < 3; j++)
    begin
      seq(DAM_SEQ_DIRECT, {8'h00, 2'(j), 14'h0000});
      chk(src_sel[SRC_PC].ram, 3'h1 << j);
    end
    seq(DAM_SEQ_DIRECT, BOOT_LAST);
    chk(src_sel[SRC_PC].rom, 1'b1);
    // 8-bit external bus: plain fetch doubles, packed fetch triples the word
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, REG_CTRL, j ? 32'h00000006 : 32'h00000002);
      seq(DAM_SEQ_DIRECT, 24'h400001);
      @(negedge mclk);
      chk(last_addr, j ? 20'h00003 : 20'h00002);
    end
    bus(1'b1, REG_CTRL, 32'h00000000);
    // last on chip io word, then first external io word
    for (int j = 0; j < 2; j++)
    begin
      @(posedge mclk);
      io_req <= '{1'b1, j ? 18'h08000 : 18'h07FFF};
      issue();
      chk({periph_sel, io_space_select_n}, j ? 2'b00 : 2'b11);
    end
    // data and fetch together: internal fetch shares, external fetch loses
    for (int j = 0; j < 2; j++)
    begin
      @(posedge mclk);
      dag_acc[0] <= '{1'b1, 2'h1, 2'h0, 1'b1};
      seq_cmd <= '{DAM_SEQ_DIRECT, j ? 24'h400000 : 24'h000000};
      issue();
      chk({src_sel[SRC_D0].ext, src_sel[SRC_PC].ram[0], ext_stall}, j ? 3'h5 : 3'h6);
      chk(ext_owner, DAM_OWN_D0);
    end
    summarize();
  end
endmodule // dam_addr_map_bench
